/* logic/sstc_core.sv */
// Contract
// RULE_01 - sync byte every N clocks; codes 0-3 mean 32-35, 4-1F mean code
// RULE_02 - software sets fast transfer enable when rate exceeds 5 MB/s
// RULE_03 - period register resets to five; bus reset leaves it alone
// RULE_04 - software never programs fewer than four clocks per byte
// RULE_05 - flags low five bits give FIFO byte count
// RULE_06 - top bits mirror sequence step; test mode bit 5 shows offset nonzero (code shows outstanding count below offset)
// RULE_07 - software should not poll FIFO count during transfer
// RULE_08 - bits 7-6 pick sync deassert delay, table depends on fast clock
// RULE_09 - bits 5-4 pick assert delay 0 to 1.5 clocks, fast clock independent
// RULE_10 - zero offset means async; nonzero means sync with that offset
// RULE_11 - transmit stops at offset, then one byte per acknowledge
// RULE_12 - receive issues one acknowledge per byte drained, offset up to 15
// RULE_13 - offset register clears on chip reset, not bus reset
// RULE_14 - slow cable adds one clock between data and REQ/ACK
// RULE_15 - bus reset interrupts unless disabled; re-interrupt while still active
// RULE_16 - parity test mode sends bit 7 as parity
// RULE_17 - parity check flags errors except pad bytes; initiator raises ATN
// RULE_18 - chip test mode sticks until hardware or chip reset
// RULE_19 - own bus ID field drives selection and arbitration identity
// RULE_20 - config register reads back written value; clears on chip reset only (code also clears it on hardware reset)
// RULE_21 - software sets conversion factor from clock frequency
// RULE_22 - factor 000 means eight; long timings scale; reset value 010
// RULE_23 - period sets minimum spacing between REQ/ACK leading edges
// RULE_24 - half clock delays use falling edge timing
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sstc_core (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic chip_reset_cmd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [2:0] seq_step,
	input wire logic [4:0] fifo_count,
	input wire logic sync_phase,
	input wire logic xfer_out,
	input wire logic initiator_role,
	input wire logic byte_ready,
	input wire logic [7:0] tx_byte,
	input wire logic peer_ack_in,
	input wire logic fifo_drain,
	input wire logic rx_strobe,
	input wire logic [7:0] rx_byte,
	input wire logic rx_parity,
	input wire logic rx_pad,
	input wire logic bus_reset_in,
	input wire logic irq_clear,
	output logic req_ack_out,
	output logic [7:0] bus_data_out,
	output logic bus_parity_out,
	output logic byte_taken,
	output logic ack_out_pulse,
	output logic atn_out,
	output logic parity_error,
	output logic bus_reset_irq,
	output logic bus_disconnect,
	output logic test_mode,
	output logic [2:0] own_bus_id,
	output logic [3:0] clock_scale,
	output logic [7:0] long_unit_cycles
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic hard_rst;
	logic [4:0] period;
	logic [7:0] offset_ctl;
	logic [7:0] config1;
	logic [2:0] scale_code;
	logic [1:0] config3;
	logic [3:0] outstanding;
	logic [3:0] rx_pending;
	logic [5:0] spacing_cnt;
	logic [2:0] phase_cnt;
	logic half_rise;
	logic half_fall;
	logic fall_q;
	sstc_pkg::sstc_phase_e phase;
	logic [5:0] clocks_per_byte;
	logic sync_mode;
	logic can_send;
	logic [2:0] assert_half;
	logic [2:0] deassert_half;
	logic [2:0] setup_cycles;

	assign hard_rst = sys_rst | chip_reset_cmd;

	function automatic logic [5:0] period_clocks(input logic [4:0] code);
		if (code < 5'h04)
			period_clocks = sstc_pkg::PERIOD_WRAP_BASE + {1'b0, code};
		else
			period_clocks = {1'b0, code};
	endfunction

	// delays counted in half clocks
	function automatic logic [2:0] half_steps(input logic [1:0] sel);
		half_steps = {1'b0, sel};
	endfunction

	assign clocks_per_byte = period_clocks(period); // RULE_01
	assign sync_mode = offset_ctl[3:0] != 4'h0; // RULE_10
	assign can_send = outstanding < offset_ctl[3:0]; // RULE_11
	assign assert_half = half_steps(offset_ctl[5:4]); // RULE_09
	assign setup_cycles = config1[sstc_pkg::CFG_SLOW_CABLE] ? 3'h2 : 3'h1; // RULE_14

	always_comb
	begin
		// slow clocks put the early step before the nominal edge
		deassert_half = half_steps(offset_ctl[7:6]); // RULE_08
		if (!config3[sstc_pkg::CFG3_HIGH_FREQ])
		begin
			if (offset_ctl[7:6] == 2'h1)
				deassert_half = 3'h0;
			else if (offset_ctl[7:6] == 2'h3)
				deassert_half = 3'h1;
		end
		if (!sync_phase)
			deassert_half = 3'h0;
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (hard_rst)
			period <= sstc_pkg::PERIOD_RESET; // RULE_03
		else if (reg_wr && reg_addr == sstc_pkg::REG_PERIOD)
			period <= reg_wdata[4:0];
	end

	always_ff @(posedge clock)
	begin
		if (hard_rst)
			offset_ctl <= sstc_pkg::OFFSET_RESET; // RULE_13
		else if (reg_wr && reg_addr == sstc_pkg::REG_FIFO_OFFSET)
			offset_ctl <= reg_wdata;
	end

	always_ff @(posedge clock)
	begin
		if (hard_rst)
			config1 <= sstc_pkg::CONFIG_RESET; // RULE_20
		else if (reg_wr && reg_addr == sstc_pkg::REG_CONFIG)
			config1 <= reg_wdata;
	end

	always_ff @(posedge clock)
	begin
		if (hard_rst)
			scale_code <= sstc_pkg::CLOCK_SCALE_RESET; // RULE_22
		else if (reg_wr && reg_addr == sstc_pkg::REG_CLOCK_SCALE)
			scale_code <= reg_wdata[2:0];
	end

	always_ff @(posedge clock)
	begin
		if (hard_rst)
			config3 <= 2'h0;
		else if (reg_wr && reg_addr == sstc_pkg::REG_CONFIG3)
			config3 <= reg_wdata[1:0];
	end

	// only a hardware or chip reset leaves test mode
	always_ff @(posedge clock)
	begin
		if (hard_rst)
			test_mode <= 1'b0;
		else if (config1[sstc_pkg::CFG_CHIP_TEST])
			test_mode <= 1'b1; // RULE_18
	end

	always_ff @(posedge clock)
	begin
		if (hard_rst)
		begin
			own_bus_id <= 3'h0;
			clock_scale <= {1'b0, sstc_pkg::CLOCK_SCALE_RESET}; // RULE_22
			long_unit_cycles <= sstc_pkg::SCALE_UNIT_CYCLES;
		end
		else
		begin
			own_bus_id <= config1[2:0]; // RULE_19
			clock_scale <= (scale_code == 3'h0) ? sstc_pkg::SCALE_ZERO_AS : {1'b0, scale_code};
			long_unit_cycles <= sstc_pkg::SCALE_UNIT_CYCLES; // RULE_22
		end
	end

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (!reg_rd)
			reg_rdata <= 8'h00;
		else if (reg_addr == sstc_pkg::REG_FIFO_OFFSET)
		begin
			// count moves while the bus side works the fifo
			reg_rdata <= {seq_step, fifo_count}; // RULE_05
			if (test_mode)
				reg_rdata[5] <= can_send; // RULE_06
		end
		else if (reg_addr == sstc_pkg::REG_CONFIG)
			reg_rdata <= config1; // RULE_20
		else if (reg_addr == sstc_pkg::REG_CONFIG3)
			reg_rdata <= {6'h00, config3};
		else if (reg_addr == sstc_pkg::REG_STATUS)
			reg_rdata <= {4'h0, outstanding};
		else
			reg_rdata <= 8'h00;
	end

	// ----------------------------------------
	// req/ack timing
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (hard_rst)
			spacing_cnt <= 6'h00;
		else if (phase == sstc_pkg::SSTC_ASSERT && phase_cnt == 3'h0)
			spacing_cnt <= clocks_per_byte - 6'h01; // RULE_23
		else if (spacing_cnt != 6'h00)
			spacing_cnt <= spacing_cnt - 6'h01;
	end

	always_ff @(posedge clock)
	begin
		if (hard_rst)
		begin
			phase <= sstc_pkg::SSTC_IDLE;
			phase_cnt <= 3'h0;
			half_rise <= 1'b0;
			bus_data_out <= 8'h00;
			bus_parity_out <= 1'b0;
			byte_taken <= 1'b0;
		end
		else
		begin
			byte_taken <= 1'b0;
			case (phase)
				sstc_pkg::SSTC_IDLE:
				begin
					half_rise <= 1'b0;
					if (byte_ready && xfer_out && spacing_cnt == 6'h00 && (!sync_mode || can_send))
					begin
						bus_data_out <= tx_byte;
						bus_parity_out <= config1[sstc_pkg::CFG_PARITY_TEST] ? tx_byte[7] : ~^tx_byte; // RULE_16
						byte_taken <= 1'b1;
						phase <= sstc_pkg::SSTC_SETUP;
						phase_cnt <= setup_cycles - 3'h1;
					end
				end
				sstc_pkg::SSTC_SETUP:
				begin
					if (phase_cnt != 3'h0)
						phase_cnt <= phase_cnt - 3'h1;
					else
					begin
						phase <= sstc_pkg::SSTC_ASSERT;
						phase_cnt <= 3'(assert_half >> 1);
					end
				end
				sstc_pkg::SSTC_ASSERT:
				begin
					if (phase_cnt != 3'h0)
						phase_cnt <= phase_cnt - 3'h1;
					else
					begin
						half_rise <= 1'b1;
						phase <= sstc_pkg::SSTC_HOLD;
						phase_cnt <= 3'(deassert_half >> 1) + 3'h1;
					end
				end
				default:
				begin
					if (phase_cnt != 3'h0)
						phase_cnt <= phase_cnt - 3'h1;
					else
					begin
						half_rise <= 1'b0;
						phase <= sstc_pkg::SSTC_IDLE;
					end
				end
			endcase
		end
	end

	// odd half steps take the edge from the falling clock
	always_ff @(negedge clock)
	begin
		if (hard_rst)
			half_fall <= 1'b0;
		else if (phase == sstc_pkg::SSTC_ASSERT && assert_half[0])
			half_fall <= half_rise | (phase_cnt == 3'h0); // RULE_24
		else if (phase == sstc_pkg::SSTC_HOLD && deassert_half[0] && phase_cnt == 3'h0)
			half_fall <= 1'b0; // RULE_24
		else
			half_fall <= half_rise;
	end

	always_ff @(posedge clock)
	begin
		if (hard_rst)
			fall_q <= 1'b0;
		else
			fall_q <= half_fall;
	end

	always_ff @(posedge clock)
	begin
		if (hard_rst)
			req_ack_out <= 1'b0;
		else
			req_ack_out <= half_rise | (half_fall & fall_q); // RULE_09
	end

	// ----------------------------------------
	// offset accounting
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (hard_rst || !sync_mode)
			outstanding <= 4'h0;
		else if (byte_taken && !peer_ack_in)
			outstanding <= outstanding + 4'h1; // RULE_11
		else if (!byte_taken && peer_ack_in && outstanding != 4'h0)
			outstanding <= outstanding - 4'h1; // RULE_11
	end

	always_ff @(posedge clock)
	begin
		if (hard_rst || !sync_mode)
		begin
			rx_pending <= 4'h0;
			ack_out_pulse <= 1'b0;
		end
		else
		begin
			ack_out_pulse <= fifo_drain && rx_pending != 4'h0; // RULE_12
			if (rx_strobe && !(fifo_drain && rx_pending != 4'h0) && rx_pending != sstc_pkg::FIFO_DEPTH)
				rx_pending <= rx_pending + 4'h1;
			else if (!rx_strobe && fifo_drain && rx_pending != 4'h0)
				rx_pending <= rx_pending - 4'h1; // RULE_12
		end
	end

	// ----------------------------------------
	// parity and bus reset
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (hard_rst)
		begin
			parity_error <= 1'b0;
			atn_out <= 1'b0;
		end
		else if (rx_strobe && !rx_pad && config1[sstc_pkg::CFG_PARITY_CHECK]
			&& (rx_parity == ^rx_byte))
		begin
			parity_error <= 1'b1; // RULE_17
			if (initiator_role)
				atn_out <= 1'b1; // RULE_17
		end
	end

	always_ff @(posedge clock)
	begin
		if (hard_rst)
		begin
			bus_reset_irq <= 1'b0;
			bus_disconnect <= 1'b0;
		end
		else
		begin
			bus_disconnect <= bus_reset_in;
			// set wins over clear, so a held reset raises it again
			if (bus_reset_in && !config1[sstc_pkg::CFG_RESET_REPORT_DIS])
				bus_reset_irq <= 1'b1; // RULE_15
			else if (irq_clear)
				bus_reset_irq <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* logic/sstc_pkg.sv */
package sstc_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0] REG_PERIOD = 4'h6;
	localparam logic [3:0] REG_FIFO_OFFSET = 4'h7;
	localparam logic [3:0] REG_CONFIG = 4'h8;
	localparam logic [3:0] REG_CLOCK_SCALE = 4'h9;
	localparam logic [3:0] REG_SEQ_STEP = 4'hD;
	localparam logic [3:0] REG_CONFIG3 = 4'hC;
	localparam logic [3:0] REG_STATUS = 4'hE;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [4:0] PERIOD_RESET = 5'h05;
	localparam logic [7:0] OFFSET_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [2:0] CLOCK_SCALE_RESET = 3'h2;
	// ----------------------------------------
	// field positions and constants
	// ----------------------------------------
	localparam int CFG_SLOW_CABLE = 7;
	localparam int CFG_RESET_REPORT_DIS = 6;
	localparam int CFG_PARITY_TEST = 5;
	localparam int CFG_PARITY_CHECK = 4;
	localparam int CFG_CHIP_TEST = 3;
	localparam int CFG3_FAST_XFER = 1;
	localparam int CFG3_HIGH_FREQ = 0;
	localparam logic [5:0] PERIOD_WRAP_BASE = 6'h20;
	localparam logic [5:0] PERIOD_MIN = 6'h04;
	localparam logic [3:0] FIFO_DEPTH = 4'hF;
	localparam logic [3:0] SCALE_ZERO_AS = 4'h8;
	// 200 ns threshold, counts beyond it scale with the factor
	localparam int SCALE_UNIT_NS = 200;
	localparam int CLOCK_PERIOD_NS = 4;
	localparam logic [7:0] SCALE_UNIT_CYCLES = 8'(SCALE_UNIT_NS / CLOCK_PERIOD_NS);
	typedef enum logic [1:0] {SSTC_IDLE, SSTC_SETUP, SSTC_ASSERT, SSTC_HOLD} sstc_phase_e;
endpackage

/* testbench/sstc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sstc_checker (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic chip_reset_cmd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic fifo_drain,
	input wire logic bus_reset_in,
	input wire logic [7:0] bus_data_out,
	input wire logic bus_parity_out,
	input wire logic byte_taken,
	input wire logic ack_out_pulse,
	input wire logic bus_reset_irq,
	input wire logic bus_disconnect,
	input wire logic test_mode,
	input wire logic [2:0] own_bus_id,
	input wire logic [3:0] clock_scale
);
	// ----
	// shadow of config bits the checks depend on
	// ----
	logic parity_test_mode;
	logic bus_reset_report_disable;
	always_ff @(posedge clock)
	begin
		if (sys_rst || chip_reset_cmd)
		begin
			parity_test_mode <= 1'b0;
			bus_reset_report_disable <= 1'b0;
		end
		else if (reg_wr && reg_addr == sstc_pkg::REG_CONFIG)
		begin
			parity_test_mode <= reg_wdata[5];
			bus_reset_report_disable <= reg_wdata[6];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
		else $error("read data outside read slot");
	a_config_echo: assert property (reg_rd && reg_addr == sstc_pkg::REG_CONFIG |=> reg_rdata[2:0] == own_bus_id)
		else $error("bus id differs from config read");
	a_test_sticky: assert property (test_mode && !chip_reset_cmd |=> test_mode)
		else $error("test mode dropped without chip reset");
	a_ack_drain: assert property (ack_out_pulse |-> $past(fifo_drain))
		else $error("acknowledge without drain");
	a_taken_pulse: assert property (byte_taken |=> !byte_taken)
		else $error("bytes taken too close");
	a_parity_src: assert property (byte_taken |-> bus_parity_out == (parity_test_mode ? bus_data_out[7] : ~^bus_data_out))
		else $error("wrong parity source");
	a_disc_follow: assert property (bus_disconnect == $past(bus_reset_in))
		else $error("disconnect does not follow bus reset");
	a_irq_raise: assert property ($rose(bus_reset_in) && !bus_reset_report_disable |-> ##[1:3] bus_reset_irq)
		else $error("bus reset not reported");
	a_irq_quiet: assert property (bus_reset_report_disable && !bus_reset_irq |=> !bus_reset_irq)
		else $error("bus reset reported while disabled");
	a_scale_zero: assert property (reg_wr && reg_addr == sstc_pkg::REG_CLOCK_SCALE && reg_wdata[2:0] == 3'h0 |-> ##2 clock_scale == 4'h8)
		else $error("factor zero not eight");
endmodule
`default_nettype wire

/* testbench/sstc_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module sstc_peer (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic req_ack_out,
	input wire logic [4:0] lag,
	output logic peer_ack_in
);
	// ----
	// one acknowledge per request, lag cycles late
	// ----
	logic req_d = 1'b0;
	int now = 0;
	int due[$];
	initial peer_ack_in = 1'b0;
	always @(posedge clock)
	begin
		req_d <= req_ack_out;
		now <= now + 1;
		peer_ack_in <= 1'b0;
		if (sys_rst)
			due.delete();
		else
		begin
			if (req_ack_out && !req_d)
				due.push_back(now + lag);
			if (due.size() > 0 && due[0] <= now)
			begin
				void'(due.pop_front());
				peer_ack_in <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin bad_count++; $display("Error %0t: got %h want %h", $time, g, w); end end
module tb_top;
	logic clock = 0, sys_rst = 1, chip_reset_cmd = 0, reg_wr = 0, reg_rd = 0, sync_phase = 0;
	logic xfer_out = 0, initiator_role = 1, byte_ready = 0, fifo_drain = 0, rx_strobe = 0;
	logic rx_parity = 0, rx_pad = 0, bus_reset_in = 0, irq_clear = 0, peer_ack_in, req_ack_out;
	logic bus_parity_out, byte_taken, ack_out_pulse, atn_out, parity_error, bus_reset_irq;
	logic bus_disconnect, test_mode, rd_d = 0, req_d = 0, parity_test_mode = 0;
	logic [3:0] reg_addr = 0, clock_scale;
	logic [7:0] reg_wdata = 0, tx_byte = 0, rx_byte = 0, reg_rdata, bus_data_out, long_unit_cycles, b, e;
	logic [2:0] seq_step = 0, own_bus_id;
	logic [4:0] fifo_count = 0, lag = 0;
	logic [31:0] seed = 32'hA5D1D8CD;
	logic [7:0] rq[$], tq[$];
	int bad_count = 0, tests_run = 0, cyc = 0, gap = 0, nmin = 0, rises = 0, acks = 0, acko = 0, k;
	sstc_core sstc_core_inst (.*);
	sstc_peer sstc_peer_inst (.*);
	always #2 clock = ~clock;
	// ----
	// helpers
	// ----
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic stop_test();
		$display("compares %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] w);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(w);
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rx(input logic [7:0] d, input logic p, input logic pad);
		rx_byte <= d;
		rx_parity <= p;
		rx_pad <= pad;
		rx_strobe <= 1'b1;
		@(posedge clock);
		rx_strobe <= 1'b0;
		@(posedge clock);
	endtask
	task automatic clr();
		irq_clear <= 1'b1;
		@(posedge clock);
		irq_clear <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task automatic run(input logic [7:0] code, input logic [7:0] cfg, input logic [4:0] l);
		nmin = code < 8'h04 ? 32 + code : code;
		parity_test_mode = cfg[5];
		lag <= l;
		wr(sstc_pkg::REG_CONFIG, cfg);
		wr(sstc_pkg::REG_PERIOD, code);
		b = rnd();
		wr(sstc_pkg::REG_FIFO_OFFSET, {b[7:4], 4'h2});
		rises = 0;
		acks = 0;
		sync_phase <= 1'b1;
		xfer_out <= 1'b1;
		byte_ready <= 1'b1;
		repeat (4)
		begin
			b = rnd();
			tx_byte <= b;
			tq.push_back(b);
			k = 0;
			do @(posedge clock); while (byte_taken !== 1'b1 && ++k < 300);
		end
		byte_ready <= 1'b0;
		repeat (80) @(posedge clock);
		xfer_out <= 1'b0;
		sync_phase <= 1'b0;
		`CHK(rises, 4)
	endtask
	// ----
	// watchers: reads, requests, acknowledges, timeout
	// ----
	always @(posedge clock)
	begin
		rd_d <= reg_rd;
		req_d <= req_ack_out;
		cyc <= cyc + 1;
		gap <= xfer_out ? gap + 1 : 1000;
		if (peer_ack_in)
			acks <= acks + 1;
		if (ack_out_pulse)
			acko <= acko + 1;
		if (rd_d)
		begin
			e = rq.pop_front();
			`CHK(reg_rdata, e)
		end
		if (req_ack_out && !req_d)
		begin
			e = tq.pop_front();
			`CHK(bus_data_out, e)
			`CHK(bus_parity_out, parity_test_mode ? e[7] : ~^e)
			`CHK(gap >= nmin, 1'b1)
			`CHK(rises - acks < 2, 1'b1)
			gap <= 1;
			rises <= rises + 1;
		end
		if (cyc == 20000)
		begin
			bad_count++;
			stop_test();
		end
	end
	initial
	begin
		b = rnd();
		seq_step = b[2:0];
		fifo_count = b[7:3];
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd(sstc_pkg::REG_CONFIG, 8'h00);
		rd(sstc_pkg::REG_FIFO_OFFSET, {seq_step, fifo_count});
		rd(4'hF, 8'h00);
		`CHK(long_unit_cycles, 8'h32)
		repeat (4)
		begin
			b = rnd() & 8'hF7;
			wr(sstc_pkg::REG_CONFIG, b);
			rd(sstc_pkg::REG_CONFIG, b);
			`CHK(own_bus_id, b[2:0])
		end
		for (int c = 0; c < 8; c++)
		begin
			if (c == 1)
				continue;
			wr(sstc_pkg::REG_CLOCK_SCALE, 8'(c));
			@(posedge clock);
			`CHK(clock_scale, c == 0 ? 4'h8 : 4'(c))
		end
		wr(sstc_pkg::REG_CONFIG3, 8'h03);
		run(8'h04, 8'h00, 5'd20);
		run(8'h00, 8'hA0, 5'd0);
		wr(sstc_pkg::REG_CONFIG, 8'h10);
		rx(8'h5A, 1'b0, 1'b1);
		rx(8'h5A, 1'b1, 1'b0);
		`CHK(parity_error, 1'b0)
		rx(8'h5A, 1'b0, 1'b0);
		`CHK({parity_error, atn_out}, 2'b11)
		acko = 0;
		repeat (3)
		begin
			fifo_drain <= 1'b1;
			@(posedge clock);
			fifo_drain <= 1'b0;
			@(posedge clock);
		end
		@(posedge clock);
		`CHK(acko, 3)
		wr(sstc_pkg::REG_CONFIG, 8'h45);
		bus_reset_in <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK({bus_reset_irq, bus_disconnect}, 2'b01)
		bus_reset_in <= 1'b0;
		rd(sstc_pkg::REG_CONFIG, 8'h45);
		wr(sstc_pkg::REG_CONFIG, 8'h05);
		bus_reset_in <= 1'b1;
		repeat (3) @(posedge clock);
		clr();
		`CHK(bus_reset_irq, 1'b1)
		bus_reset_in <= 1'b0;
		clr();
		`CHK(bus_reset_irq, 1'b0)
		wr(sstc_pkg::REG_CONFIG, 8'h08);
		wr(sstc_pkg::REG_CONFIG, 8'h00);
		`CHK(test_mode, 1'b1)
		rd(sstc_pkg::REG_FIFO_OFFSET, {seq_step[2:1], 1'b1, fifo_count});
		chip_reset_cmd <= 1'b1;
		@(posedge clock);
		chip_reset_cmd <= 1'b0;
		@(posedge clock);
		`CHK(test_mode, 1'b0)
		rd(sstc_pkg::REG_CONFIG, 8'h00);
		@(posedge clock);
		stop_test();
	end
endmodule
bind sstc_core sstc_checker sstc_checker_inst (.*);
`default_nettype wire
